// [cpp_top.v]
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "cpp_defs.vh"
// Contract
// - Master sends one position each NC cycle; NC cycle is the time base.
// - Drive-controlled mode enters cyclic control smoothly despite jumps.
// - Commands are filtered, then fine-interpolated to controller clock.
// - Control word selects feedback source and lagless or lag-error control.
// - Every received command is copied to a display register.
// - Reading the command returns the value applied at controller input.
// - Moving average up to 64 cycles, order reported, set by time constant.
// - Optional anti-vibration filter by frequency and damping; delay reported (code: frequency only enables it, CPP_A_AVDL reads the on bit).
// - Each cycle-to-cycle difference is checked against velocity limits.
// - Processing mode selects the fine interpolation method.
// - Command can be delayed up to 64 controller clocks.
// - Extension word of 2^15 scaled remainder refines velocity, acceleration.
// - Additive position value is added before the controller.
// - Velocity and acceleration feedforward derived from position sequence.
// - Missing command values from the master are detected.
// - Feedback source may be switched while control runs.
// - Velocity feedforward scaled 0 to 120 percent, default 100.
// - Additive torque command taken every cycle as acceleration feedforward.
// - Mode runs only with clock-synchronized communication.
// - Drive mode ramps from actual position, then sets done bit 0.
// - NC-controlled mode follows master commands directly.
// - Activation loads command copy once with own current command.
// - A missing command value is extrapolated.
// - Excess difference raises error or warning; both values recorded.
module cpp_top #(
  parameter PC_CYC = `CPP_PC_NS / `CPP_CLK_NS
) (
  input wire mclk,
  input wire rst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire link_sync,
  input wire cmd_valid,
  input wire signed [31:0] cmd_pos,
  input wire [15:0] cmd_ext,
  input wire [15:0] cmd_torque,
  input wire [31:0] act_pos1,
  input wire [31:0] act_pos2,
  input wire [31:0] act_hyb,
  output reg signed [31:0] pos_out,
  output reg pos_strobe,
  output reg signed [31:0] vel_ff,
  output reg signed [31:0] acc_ff,
  output reg [15:0] torque_ff,
  output reg [31:0] fb_pos,
  output reg lagless,
  output reg nc_controlled_axis_word_diag,
  output reg drive_controlled_axis_word_diag,
  output reg excess_difference_error,
  output reg excess_difference_warning
);
  localparam [31:0] PC_LAST = PC_CYC - 1;

  reg [6:0] ctrl;
  reg proc_hold;
  reg proc_warn;
  reg [2:0] nc_cycle_time;
  reg signed [31:0] vlim_p;
  reg signed [31:0] vlim_n;
  reg [15:0] avg_tc;
  reg [15:0] av_freq;
  reg [7:0] av_damp;
  reg [6:0] dly_n;
  reg signed [31:0] add_pos;
  reg [6:0] vff_pct;
  reg [31:0] s_acc;
  reg [31:0] s_vel;
  reg [31:0] s_win;
  reg [1:0] s_dir;
  reg sync_done;
  reg st_miss;
  reg signed [31:0] cmd_copy;
  reg signed [31:0] excess_val;
  reg signed [31:0] last_rec;
  reg aw_hold;
  reg w_hold;
  reg [7:0] aw_a;
  reg [31:0] w_d;
  reg [3:0] w_s;

  function [2:0] ord_log;
    input [15:0] tc;
    integer i;
    begin
      ord_log = 3'h0;
      for (i = 1; i < 7; i = i + 1) begin
        if (tc >= (16'h0001 << i)) begin
          ord_log = i[2:0];
        end
      end
    end
  endfunction

  wire [2:0] ord = ord_log(avg_tc);
  wire [6:0] order = 7'h01 << ord;
  wire av_on = (av_freq != 16'h0000);

  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] d;
    input [3:0] s;
    integer b;
    begin
      wmerge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (s[b]) begin
          wmerge[8*b +: 8] = d[8*b +: 8];
        end
      end
    end
  endfunction

  // Top bit flags a mapped address
  function [32:0] rd_reg;
    input [7:0] a;
    begin
      case (a)
        `CPP_A_CTRL: rd_reg = {1'b1, 25'h0, ctrl};
        `CPP_A_PROC: rd_reg = {1'b1, 16'h0, proc_warn, 14'h0, proc_hold};
        `CPP_A_NCT: rd_reg = {1'b1, 29'h0, nc_cycle_time};
        `CPP_A_VLP: rd_reg = {1'b1, vlim_p};
        `CPP_A_VLN: rd_reg = {1'b1, vlim_n};
        `CPP_A_AVGTC: rd_reg = {1'b1, 16'h0, avg_tc};
        `CPP_A_AVFRQ: rd_reg = {1'b1, 16'h0, av_freq};
        `CPP_A_AVDMP: rd_reg = {1'b1, 24'h0, av_damp};
        `CPP_A_DLY: rd_reg = {1'b1, 25'h0, dly_n};
        `CPP_A_ADD: rd_reg = {1'b1, add_pos};
        `CPP_A_VFF: rd_reg = {1'b1, 25'h0, vff_pct};
        `CPP_A_SACC: rd_reg = {1'b1, s_acc};
        `CPP_A_SVEL: rd_reg = {1'b1, s_vel};
        `CPP_A_SDIR: rd_reg = {1'b1, 30'h0, s_dir};
        `CPP_A_SWIN: rd_reg = {1'b1, s_win};
        `CPP_A_STAT: rd_reg = {1'b1, 28'h0, st_miss,
          excess_difference_warning, excess_difference_error, sync_done};
        `CPP_A_COPY: rd_reg = {1'b1, cmd_copy};
        `CPP_A_APPL: rd_reg = {1'b1, pos_out};
        `CPP_A_ORD: rd_reg = {1'b1, 25'h0, order};
        `CPP_A_AVDL: rd_reg = {1'b1, 31'h0, av_on};
        `CPP_A_EXCV: rd_reg = {1'b1, excess_val};
        `CPP_A_LASTV: rd_reg = {1'b1, last_rec};
        default: rd_reg = {1'b0, 32'h0000_0000};
      endcase
    end
  endfunction

  wire [32:0] rd_w = rd_reg(aw_a);
  wire [32:0] rd_r = rd_reg(s_axi_araddr);
  wire [31:0] wv = wmerge(rd_w[31:0], w_d, w_s);
  wire wr_go = aw_hold & w_hold;
  wire st_wr = wr_go & (aw_a == `CPP_A_STAT);
  wire [3:0] clr = {4{st_wr & w_s[0]}} & w_d[3:0];

  // Bus slave: address and data may arrive in either order
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CPP_RESP_OK;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `CPP_RESP_OK;
      s_axi_rdata <= 32'h0000_0000;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_a <= 8'h00;
      w_d <= 32'h0000_0000;
      w_s <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_a <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold <= 1'b1;
        s_axi_wready <= 1'b0;
        w_d <= s_axi_wdata;
        w_s <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= rd_w[32] ? `CPP_RESP_OK : `CPP_RESP_ERR;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_r[31:0];
        s_axi_rresp <= rd_r[32] ? `CPP_RESP_OK : `CPP_RESP_ERR;
      end
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `CPP_R_CTRL;
      proc_hold <= 1'b0;
      proc_warn <= 1'b0;
      nc_cycle_time <= `CPP_R_NCT;
      vlim_p <= 32'h7fff_ffff;
      vlim_n <= 32'h7fff_ffff;
      avg_tc <= 16'h0000;
      av_freq <= 16'h0000;
      av_damp <= 8'h00;
      dly_n <= 7'h00;
      add_pos <= 32'h0000_0000;
      vff_pct <= `CPP_R_VFF;
      s_acc <= 32'h0000_0001;
      s_vel <= 32'h0000_0001;
      s_win <= 32'h0000_0000;
      s_dir <= 2'h0;
    end else if (wr_go) begin
      case (aw_a)
        `CPP_A_CTRL: ctrl <= wv[6:0];
        `CPP_A_PROC: begin
          proc_hold <= wv[`CPP_P_HOLD];
          proc_warn <= wv[`CPP_P_WARN];
        end
        `CPP_A_NCT: nc_cycle_time <= wv[2:0];
        `CPP_A_VLP: vlim_p <= wv;
        `CPP_A_VLN: vlim_n <= wv;
        `CPP_A_AVGTC: avg_tc <= wv[15:0];
        `CPP_A_AVFRQ: av_freq <= wv[15:0];
        `CPP_A_AVDMP: av_damp <= wv[7:0];
        `CPP_A_DLY: dly_n <= (wv > 32'h0000_0040) ?
          `CPP_MAX_DLY : wv[6:0];
        `CPP_A_ADD: add_pos <= wv;
        `CPP_A_VFF: vff_pct <= (wv > 32'h0000_0078) ?
          `CPP_VFF_MAX : wv[6:0];
        `CPP_A_SACC: s_acc <= wv;
        `CPP_A_SVEL: s_vel <= wv;
        `CPP_A_SDIR: s_dir <= wv[1:0];
        `CPP_A_SWIN: s_win <= wv;
        default: ;
      endcase
    end
  end

  // Controller clock and NC cycle phase
  reg [31:0] pc_cnt;
  reg pc_tick;
  reg [7:0] phase;
  reg act_q;
  wire act = ctrl[`CPP_C_EN] & link_sync;
  wire act_rise = act & ~act_q;
  wire drv = ctrl[`CPP_C_DRV];
  wire [7:0] ph_last = (8'h01 << nc_cycle_time) - 8'h01;
  wire ph_end = (phase == ph_last);
  wire nc_bnd = pc_tick & ph_end & act;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pc_cnt <= 32'h0000_0000;
      pc_tick <= 1'b0;
      phase <= 8'h00;
      act_q <= 1'b0;
    end else begin
      pc_cnt <= (pc_cnt == PC_LAST) ? 32'h0000_0000 : pc_cnt + 32'h1;
      pc_tick <= (pc_cnt == PC_LAST);
      act_q <= act;
      if (!act) begin
        phase <= 8'h00;
      end else if (pc_tick) begin
        phase <= ph_end ? 8'h00 : phase + 8'h01;
      end
    end
  end

  // Command intake, monitoring and extrapolation
  reg fresh;
  reg signed [31:0] hold_pos;
  reg [14:0] hold_ext;
  reg [15:0] hold_trq;
  reg signed [31:0] lv;
  reg signed [31:0] lv_prev;
  reg signed [31:0] mon_pos;
  reg [14:0] mon_ext;
  reg mon_v;
  wire signed [31:0] cand = fresh ? hold_pos : lv + (lv - lv_prev);
  wire signed [31:0] diff = cand - lv;
  wire over = (diff > vlim_p) | (-diff > vlim_n);
  wire reject = over & ~proc_warn;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fresh <= 1'b0;
      hold_pos <= 32'h0000_0000;
      hold_ext <= 15'h0000;
      hold_trq <= 16'h0000;
      lv <= 32'h0000_0000;
      lv_prev <= 32'h0000_0000;
      mon_pos <= 32'h0000_0000;
      mon_ext <= 15'h0000;
      mon_v <= 1'b0;
      cmd_copy <= 32'h0000_0000;
      excess_val <= 32'h0000_0000;
      last_rec <= 32'h0000_0000;
      st_miss <= 1'b0;
      excess_difference_error <= 1'b0;
      excess_difference_warning <= 1'b0;
    end else begin
      fresh <= cmd_valid | (fresh & ~nc_bnd);
      mon_v <= nc_bnd;
      if (cmd_valid) begin
        hold_pos <= cmd_pos;
        hold_ext <= cmd_ext[14:0];
        hold_trq <= cmd_torque;
      end
      if (act_rise) begin
        cmd_copy <= pos_out;
        lv <= pos_out;
        lv_prev <= pos_out;
      end else begin
        if (cmd_valid) begin
          cmd_copy <= cmd_pos;
        end
        if (nc_bnd) begin
          if (!reject) begin
            lv <= cand;
            lv_prev <= lv;
          end
          mon_pos <= reject ? lv : cand;
          mon_ext <= fresh ? hold_ext : mon_ext;
          if (over) begin
            excess_val <= cand;
            last_rec <= lv;
          end
        end
      end
      // A new event in the clearing cycle keeps its flag
      st_miss <= (nc_bnd & ~fresh) | (st_miss & ~clr[3]);
      excess_difference_error <= (nc_bnd & reject) |
        (excess_difference_error & ~clr[1]);
      excess_difference_warning <= (nc_bnd & over & proc_warn) |
        (excess_difference_warning & ~clr[2]);
    end
  end

  // Anti-vibration stage ahead of the average
  reg signed [31:0] av_out;
  reg av_v;
  wire signed [32:0] av_d = mon_pos - av_out;
  wire signed [41:0] av_p = av_d * $signed({1'b0, av_damp});
  wire signed [41:0] av_s = av_p >>> 8;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      av_out <= 32'h0000_0000;
      av_v <= 1'b0;
    end else begin
      av_v <= mon_v;
      if (act_rise) begin
        av_out <= pos_out;
      end else if (mon_v) begin
        av_out <= av_on ? av_out + av_s[31:0] : mon_pos;
      end
    end
  end

  wire avg_v;
  wire signed [31:0] avg_d;

  cpp_avg u_avg (
    .mclk(mclk),
    .rst_n(rst_n),
    .restart(act_rise),
    .in_valid(av_v),
    .in_data(av_out),
    .ord_log(ord),
    .out_valid(avg_v),
    .out_data(avg_d)
  );

  // Fine interpolation to the controller clock
  reg signed [31:0] tgt;
  reg signed [31:0] stp;
  reg signed [31:0] ip;
  wire signed [31:0] tdif = avg_d - tgt;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tgt <= 32'h0000_0000;
      stp <= 32'h0000_0000;
      ip <= 32'h0000_0000;
    end else if (act_rise) begin
      tgt <= pos_out;
      stp <= 32'h0000_0000;
      ip <= pos_out;
    end else begin
      if (avg_v) begin
        tgt <= avg_d;
        stp <= tdif >>> nc_cycle_time;
      end
      if (pc_tick & act) begin
        ip <= (proc_hold | ph_end) ? tgt : ip + stp;
      end
    end
  end

  // Delay ring, synchronisation ramp and output stage
  reg td1;
  reg td2;
  reg [5:0] wp;
  reg [5:0] rp;
  reg sync_on;
  reg signed [31:0] spos;
  reg [31:0] sv;
  wire [31:0] dly_rd;
  wire signed [31:0] dly_v = (dly_n == 7'h00) ? ip : dly_rd;
  reg signed [31:0] s_err;
  reg [31:0] s_aerr;
  reg [32:0] s_vn;
  reg [31:0] s_stp;
  reg s_neg;

  cpp_ram #(.W(32)) u_dly (
    .mclk(mclk),
    .we(td1),
    .waddr(wp),
    .wdata(ip),
    .raddr(rp),
    .rdata(dly_rd)
  );

  always @* begin
    s_err = dly_v - spos;
    s_aerr = s_err[31] ? -s_err : s_err;
    s_vn = {1'b0, sv} + {1'b0, s_acc};
    if (s_vn > {1'b0, s_vel}) begin
      s_vn = {1'b0, s_vel};
    end
    s_stp = (s_vn[31:0] > s_aerr) ? s_aerr : s_vn[31:0];
    case (s_dir)
      2'h1: s_neg = 1'b0;
      2'h2: s_neg = 1'b1;
      default: s_neg = s_err[31];
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      td1 <= 1'b0;
      td2 <= 1'b0;
      wp <= 6'h00;
      rp <= 6'h00;
      sync_on <= 1'b0;
      sync_done <= 1'b0;
      spos <= 32'h0000_0000;
      sv <= 32'h0000_0000;
      pos_out <= 32'h0000_0000;
      pos_strobe <= 1'b0;
    end else begin
      td1 <= pc_tick & act;
      td2 <= td1;
      pos_strobe <= td2;
      if (td1) begin
        wp <= wp + 6'h01;
      end
      rp <= wp - dly_n[5:0];
      if (act_rise) begin
        sync_on <= drv;
        sync_done <= 1'b0;
        spos <= fb_pos;
        sv <= 32'h0000_0000;
      end else if (td2) begin
        if (sync_on) begin
          if (s_aerr <= s_win) begin
            sync_on <= 1'b0;
            sync_done <= 1'b1;
          end else begin
            sv <= s_vn[31:0];
            spos <= s_neg ? spos - s_stp : spos + s_stp;
          end
        end
        pos_out <= (sync_on ? spos : dly_v) + add_pos;
      end
      if (clr[0] & ~(td2 & sync_on & (s_aerr <= s_win))) begin
        sync_done <= 1'b0;
      end
    end
  end

  // Feedforward at NC rate with the extension remainder
  reg signed [47:0] fine_q;
  reg signed [31:0] v_q;
  wire signed [31:0] ffpos = mon_pos +
    (ctrl[`CPP_C_ADDFF] ? add_pos : 32'h0000_0000);
  wire signed [47:0] fine = {ffpos, 15'h0000, 1'b0} >>> 1 |
    {33'h0, mon_ext};
  wire signed [47:0] vfine = (fine - fine_q) >>> 7;
  wire signed [31:0] v_now = vfine[31:0];
  // Percent as a 2**24 fraction: 167772 is 2**24 / 100
  wire signed [63:0] v_sc = v_now * $signed({1'b0, vff_pct}) *
    $signed({1'b0, 18'h2_8f5c});
  wire signed [63:0] v_scs = v_sc >>> 24;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fine_q <= 48'h0000_0000_0000;
      v_q <= 32'h0000_0000;
      vel_ff <= 32'h0000_0000;
      acc_ff <= 32'h0000_0000;
      torque_ff <= 16'h0000;
      fb_pos <= 32'h0000_0000;
      lagless <= 1'b0;
      nc_controlled_axis_word_diag <= 1'b0;
      drive_controlled_axis_word_diag <= 1'b0;
    end else begin
      if (mon_v) begin
        fine_q <= fine;
        v_q <= v_now;
        vel_ff <= lagless ? v_scs[31:0] : 32'h0000_0000;
        acc_ff <= lagless ? v_now - v_q : 32'h0000_0000;
        torque_ff <= ctrl[`CPP_C_EXTACC] ? hold_trq : 16'h0000;
      end
      case (ctrl[`CPP_C_FBH:`CPP_C_FBL])
        2'h1: fb_pos <= act_pos2;
        2'h2: fb_pos <= act_hyb;
        default: fb_pos <= act_pos1;
      endcase
      lagless <= ctrl[`CPP_C_LAGLESS];
      nc_controlled_axis_word_diag <= act & ~drv;
      drive_controlled_axis_word_diag <= act & drv;
    end
  end
endmodule
`default_nettype wire

// [cpp_defs.vh]
`ifndef CPP_DEFS_VH
`define CPP_DEFS_VH
`define CPP_A_CTRL 8'h00
`define CPP_A_PROC 8'h04
`define CPP_A_NCT 8'h08
`define CPP_A_VLP 8'h0c
`define CPP_A_VLN 8'h10
`define CPP_A_AVGTC 8'h14
`define CPP_A_AVFRQ 8'h18
`define CPP_A_AVDMP 8'h1c
`define CPP_A_DLY 8'h20
`define CPP_A_ADD 8'h24
`define CPP_A_VFF 8'h28
`define CPP_A_SACC 8'h2c
`define CPP_A_SVEL 8'h30
`define CPP_A_SDIR 8'h34
`define CPP_A_SWIN 8'h38
`define CPP_A_STAT 8'h40
`define CPP_A_COPY 8'h44
`define CPP_A_APPL 8'h48
`define CPP_A_ORD 8'h4c
`define CPP_A_AVDL 8'h50
`define CPP_A_EXCV 8'h54
`define CPP_A_LASTV 8'h58
`define CPP_C_EN 0
`define CPP_C_DRV 1
`define CPP_C_FBL 2
`define CPP_C_FBH 3
`define CPP_C_LAGLESS 4
`define CPP_C_ADDFF 5
`define CPP_C_EXTACC 6
`define CPP_P_HOLD 0
`define CPP_P_WARN 15
`define CPP_R_CTRL 7'h00
`define CPP_R_NCT 3'h3
`define CPP_R_VFF 7'h64
`define CPP_VFF_MAX 7'h78
`define CPP_MAX_DLY 7'h40
`define CPP_RESP_OK 2'h0
`define CPP_RESP_ERR 2'h2
`define CPP_CLK_NS 5
`define CPP_PC_NS 250000
`endif

// [cpp_ram.v]
`timescale 1ns/100ps
`default_nettype none
// Read happens before write at the same address
module cpp_ram #(
  parameter W = 48
) (
  input wire mclk,
  input wire we,
  input wire [5:0] waddr,
  input wire [W-1:0] wdata,
  input wire [5:0] raddr,
  output reg [W-1:0] rdata
);
  reg [W-1:0] mem [0:63];

  always @(posedge mclk) begin
    rdata <= mem[raddr];
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
endmodule
`default_nettype wire

// [cpp_avg.v]
`timescale 1ns/100ps
`default_nettype none
// Moving average over 2**ord_log samples, taken as the difference of two
// running totals so that the order may change without a stale sum.
module cpp_avg (
  input wire mclk,
  input wire rst_n,
  input wire restart,
  input wire in_valid,
  input wire signed [31:0] in_data,
  input wire [2:0] ord_log,
  output reg out_valid,
  output reg signed [31:0] out_data
);
  reg signed [47:0] total;
  reg signed [31:0] x_q;
  reg [5:0] idx;
  reg [6:0] fill;
  wire signed [47:0] t_new = total + {{16{in_data[31]}}, in_data};
  wire [6:0] order = 7'h01 << ord_log;
  wire [5:0] ra = idx - order[5:0];
  wire [47:0] t_old;
  wire signed [47:0] span = total - t_old;
  wire signed [47:0] avg = span >>> ord_log;

  cpp_ram #(.W(48)) u_hist (
    .mclk(mclk),
    .we(in_valid),
    .waddr(idx),
    .wdata(t_new),
    .raddr(ra),
    .rdata(t_old)
  );

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      total <= 48'h0000_0000_0000;
      x_q <= 32'h0000_0000;
      idx <= 6'h00;
      fill <= 7'h00;
      out_valid <= 1'b0;
      out_data <= 32'h0000_0000;
    end else begin
      out_valid <= in_valid;
      if (restart) begin
        fill <= 7'h00;
      end else if (in_valid) begin
        total <= t_new;
        x_q <= in_data;
        idx <= idx + 6'h01;
        if (fill != `CPP_MAX_DLY) begin
          fill <= fill + 7'h01;
        end
      end
      // Until the window is primed the sample passes straight through
      if (out_valid) begin
        out_data <= (fill < order) ? x_q : avg[31:0];
      end
    end
  end
endmodule
`default_nettype wire

// [cpp_top_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module cpp_top_sva #(
  parameter PC_CYC = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic signed [31:0] pos_out,
  input wire logic pos_strobe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_late;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  chk_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("awready high after address taken");
  chk_w_busy: assert property (s_axi_wvalid && s_axi_wready |=>
    !s_axi_wready) else $error("wready high after data taken");
  chk_b_answer: assert property (w_take |=> b_late)
    else $error("write response not two cycles after take");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  // Spacing of seven assumes PC_CYC of 8
  chk_strobe_space: assert property (pos_strobe |=> !pos_strobe [*7])
    else $error("controller strobes too close");
  chk_pos_strobe: assert property ($changed(pos_out) |-> ##[0:1] pos_strobe)
    else $error("pos_out moved without strobe");
endmodule
bind cpp_top cpp_top_sva #(.PC_CYC(PC_CYC)) i_cpp_top_sva (.*);
`default_nettype wire

// [cpp_nc_master.sv]
`timescale 1ns/100ps
`default_nettype none
module cpp_nc_master #(
  parameter int NC_CLKS = 64
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic signed [31:0] target,
  input wire logic [15:0] torque,
  output var logic link_sync,
  output var logic cmd_valid,
  output var logic signed [31:0] cmd_pos,
  output var logic [15:0] cmd_ext,
  output var logic [15:0] cmd_torque
);
  int cnt;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      link_sync <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_pos <= 32'h0;
      cmd_ext <= 16'h0;
      cmd_torque <= 16'h0;
    end else begin
      link_sync <= 1'b1;
      cnt <= (cnt == NC_CLKS - 1) ? 0 : cnt + 1;
      cmd_valid <= run && cnt == 0;
      if (run && cnt == 0) begin
        cmd_pos <= target;
        cmd_ext <= 16'h2000;
        cmd_torque <= torque;
      end else begin
        // Payload is stale between pulses, so invert it every clock; the old value returns every second clock
        cmd_pos <= ~cmd_pos;
        cmd_ext <= ~cmd_ext;
        cmd_torque <= ~cmd_torque;
      end
    end
  end
endmodule
`default_nettype wire

// [cpp_top_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cpp_defs.vh"
module cpp_top_bench;
  logic mclk = 1'b0, rst_n = 1'b0, run = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, act_pos1 = 32'h0, act_pos2 = 32'h0;
  logic [31:0] act_hyb = 32'h0;
  logic signed [31:0] target = 32'h100;
  logic [15:0] torque = 16'h1234;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire logic s_axi_rvalid, link_sync, cmd_valid, pos_strobe, lagless;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata, vel_ff, acc_ff, fb_pos;
  wire logic signed [31:0] pos_out, cmd_pos;
  wire logic [15:0] cmd_ext, cmd_torque, torque_ff;
  wire logic nc_controlled_axis_word_diag, drive_controlled_axis_word_diag;
  wire logic excess_difference_error, excess_difference_warning;
  int mismatches = 0, tests_run = 0;
  cpp_top #(.PC_CYC(8)) i_cpp_top (.*);
  cpp_nc_master #(.NC_CLKS(64)) i_cpp_nc_master (.*);
  always #2.5 mclk = ~mclk;
  task automatic chk(input string nm, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e, m = 32'hffff_ffff,
                      input logic [1:0] er = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(nm, s_axi_rdata & m, e);
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask
  task automatic wait_nc(input int n);
    repeat (n * 64) @(posedge mclk);
  endtask
  task automatic settle(input logic [31:0] e);
    int n;
    n = 0;
    while (pos_out !== e && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    chk("pos_out", pos_out, e);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rchk("nct", `CPP_A_NCT, 32'h3);
    rchk("vlp", `CPP_A_VLP, 32'h7fff_ffff);
    rchk("vff", `CPP_A_VFF, 32'h64);
    rchk("hole", 8'h3c, 32'h0, 32'hffff_ffff, 2'h2);
    wr(8'hfc, 32'h1, 2'h2);
    $display("test reset done");
    wr(`CPP_A_VFF, 32'hc8);
    rchk("vff", `CPP_A_VFF, 32'h78);
    wr(`CPP_A_DLY, 32'h64);
    rchk("dly", `CPP_A_DLY, 32'h40);
    wr(`CPP_A_AVGTC, 32'h64);
    rchk("ord", `CPP_A_ORD, 32'h40);
    wr(`CPP_A_AVGTC, 32'h5);
    rchk("ord", `CPP_A_ORD, 32'h4);
    wr(`CPP_A_AVFRQ, 32'ha);
    rchk("avdl", `CPP_A_AVDL, 32'h1);
    wr(`CPP_A_AVFRQ, 32'h0);
    wr(`CPP_A_AVGTC, 32'h1);
    wr(`CPP_A_DLY, 32'h0);
    $display("test config done");
    act_pos1 <= 32'h100;
    act_pos2 <= 32'h200;
    act_hyb <= 32'h300;
    run <= 1'b1;
    wr(`CPP_A_CTRL, 32'h11);
    wait_nc(2);
    chk("nc_diag", 32'(nc_controlled_axis_word_diag), 32'h1);
    chk("lagless", 32'(lagless), 32'h1);
    settle(32'h100);
    rchk("copy", `CPP_A_COPY, 32'h100);
    rchk("appl", `CPP_A_APPL, 32'h100);
    wr(`CPP_A_ADD, 32'h10);
    settle(32'h110);
    wr(`CPP_A_ADD, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(`CPP_A_CTRL, 32'h51 | (i << 2));
      @(posedge mclk);
      chk("fb_pos", fb_pos, 32'h100 * (i + 1));
    end
    wait_nc(2);
    chk("torque_ff", 32'(torque_ff), 32'h1234);
    for (int m = 0; m < 2; m++) begin
      wr(`CPP_A_PROC, m);
      target <= target + 32'h40;
      settle(32'h140 + 32'h40 * m);
    end
    run <= 1'b0;
    wait_nc(3);
    rchk("missing", `CPP_A_STAT, 32'h8, 32'h8);
    settle(32'h180);
    run <= 1'b1;
    wait_nc(2);
    wr(`CPP_A_STAT, 32'h8);
    rchk("missing", `CPP_A_STAT, 32'h0, 32'h8);
    $display("test nc done");
    wr(`CPP_A_CTRL, 32'h0);
    act_pos1 <= 32'h180;
    wr(`CPP_A_SWIN, 32'h8);
    wr(`CPP_A_CTRL, 32'h3);
    wait_nc(4);
    chk("drv_diag", 32'(drive_controlled_axis_word_diag), 32'h1);
    rchk("sync", `CPP_A_STAT, 32'h1, 32'h1);
    settle(32'h180);
    $display("test drive done");
    wr(`CPP_A_VLP, 32'h20);
    target <= 32'h400;
    wait_nc(3);
    chk("err", 32'(excess_difference_error), 32'h1);
    rchk("excv", `CPP_A_EXCV, 32'h400);
    rchk("lastv", `CPP_A_LASTV, 32'h180);
    chk("held", pos_out, 32'h180);
    wr(`CPP_A_PROC, 32'h8000);
    target <= 32'h410;
    wait_nc(3);
    chk("warn", 32'(excess_difference_warning), 32'h1);
    settle(32'h410);
    $display("test excess done");
    wrap_up();
  end
endmodule
`default_nettype wire
